// ### core/t2ofc_top.sv
// timer 2 control register, overflow flags, interrupts and APB slave
//
// The APB interface to the registers was chosen for this implementation.
module t2ofc_top
(
    input wire logic MCLK_IN,
    input wire logic RESET_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic EXT_CLK_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic IRQ_OUT,
    output logic TIMER_IRQ_OUT
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    // software-visible registers first, then bus, prescaler and event wiring
    t2ofc_pkg::t2ofc_ctrl_type ctl;
    t2ofc_pkg::t2ofc_ctrl_type next_ctl;
    t2ofc_pkg::t2ofc_phase_type phase;
    t2ofc_pkg::t2ofc_phase_type next_phase;
    logic [15:0] reload;
    logic [15:0] next_reload;
    logic [2:0] cfg;
    logic [2:0] next_cfg;
    logic [1:0] irq_status;
    logic [1:0] next_irq_status;
    logic [1:0] irq_mask;
    logic [1:0] next_irq_mask;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_irq;
    logic next_timer_irq;
    logic [3:0] div12;
    logic [3:0] next_div12;
    logic [2:0] ext_div;
    logic [2:0] next_ext_div;
    logic ext_prev;
    logic ext_level;
    logic ext_rise;
    logic ext_tick;
    logic div12_tick;
    logic tick_lo;
    logic tick_hi;
    logic capture;
    logic wr;
    t2ofc_pkg::t2ofc_reg_type wr_reg;
    logic [15:0] count;
    logic ovf_lo;
    logic ovf_hi;
    logic set_hi;
    logic set_lo;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // address decode, shared by the read and the write path;
    // unmapped offsets decode to none, which answers with an error
    function automatic t2ofc_pkg::t2ofc_reg_type decode(input logic [7:0] addr);
        case (addr)
            t2ofc_pkg::TIMER2_CONTROL_ADDR: decode = t2ofc_pkg::T2OFC_REG_CONTROL;
            t2ofc_pkg::RELOAD_ADDR: decode = t2ofc_pkg::T2OFC_REG_RELOAD;
            t2ofc_pkg::COUNT_ADDR: decode = t2ofc_pkg::T2OFC_REG_COUNT;
            t2ofc_pkg::IRQ_STATUS_ADDR: decode = t2ofc_pkg::T2OFC_REG_STATUS;
            t2ofc_pkg::IRQ_MASK_ADDR: decode = t2ofc_pkg::T2OFC_REG_MASK;
            t2ofc_pkg::CONFIG_ADDR: decode = t2ofc_pkg::T2OFC_REG_CONFIG;
            default: decode = t2ofc_pkg::T2OFC_REG_NONE;
        endcase
    endfunction

    // picks the clock source of one timer byte; the sysclk select
    // outranks the external select
    function automatic logic pick_tick(input logic sys_sel, input logic ext_sel,
                                       input logic ext_t, input logic div_t);
        pick_tick = sys_sel ? 1'b1 : (ext_sel ? ext_t : div_t);
    endfunction

    // ----------------------------------------------------------------
    // clock sources
    // ----------------------------------------------------------------
    t2ofc_sync u_sync
    (
        .MCLK_IN(MCLK_IN),
        .RESET_N_IN(RESET_N_IN),
        .pin_in(EXT_CLK_IN),
        .level_out(ext_level)
    );

    // external clock divided by eight; every eighth rising pin edge is the capture event.
    // the divider runs whether or not capture is on, so the first capture
    // after enabling may come after fewer than eight pin edges
    assign ext_rise = ext_level && !ext_prev;
    assign ext_tick = ext_rise && (ext_div == t2ofc_pkg::EXT_DIV_LAST);
    assign div12_tick = (div12 == t2ofc_pkg::SYSCLK_DIV - 4'h1);
    assign capture = ext_tick && ctl.capture_mode_enable;

    // byte clocks follow the sysclk selects, then the external select;
    // in 16-bit mode only the low byte's clock is used, the high byte's
    // select then has no effect
    assign tick_lo = pick_tick(cfg[t2ofc_pkg::CFG_LOW_SYSCLK_BIT],
                               ctl.external_clock_select, ext_tick, div12_tick);
    assign tick_hi = pick_tick(cfg[t2ofc_pkg::CFG_HIGH_SYSCLK_BIT],
                               ctl.external_clock_select, ext_tick, div12_tick);

    // prescaler next values; the divide-by-twelve runs freely, so its
    // phase is not tied to any register write
    always_comb
    begin
        next_div12 = div12_tick ? 4'h0 : div12 + 4'h1;
        next_ext_div = ext_rise ? ext_div + 3'h1 : ext_div;
    end

    // ----------------------------------------------------------------
    // counting datapath
    // ----------------------------------------------------------------
    // rollovers are reported one cycle after the counting edge
    t2ofc_count u_count
    (
        .MCLK_IN(MCLK_IN),
        .RESET_N_IN(RESET_N_IN),
        .ctl_in(ctl),
        .tick_lo_in(tick_lo),
        .tick_hi_in(tick_hi),
        .reload_in(reload),
        .count_out(count),
        .ovf_lo_out(ovf_lo),
        .ovf_hi_out(ovf_hi)
    );

    // hardware flag events; capture also sets the high flag
    assign set_hi = ovf_hi || capture;
    assign set_lo = ovf_lo;

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // write lands at the access edge, when pready is already high;
    // an access phase that arrives without its setup cycle finds the
    // slave idle and is dropped, so no register can change by accident
    assign wr = (phase == t2ofc_pkg::T2OFC_ANSWER) && PSEL_IN && PENABLE_IN && PWRITE_IN;
    assign wr_reg = wr ? decode(PADDR_IN) : t2ofc_pkg::T2OFC_REG_NONE;

    // read data is sampled in setup so every output stays a flip-flop;
    // ready rises with the access phase, so every access completes with no wait state
    always_comb
    begin
        next_phase = phase;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = 32'h0000_0000;
        unique case (phase)
            t2ofc_pkg::T2OFC_IDLE:
            begin
                if (PSEL_IN && !PENABLE_IN)
                begin
                    next_phase = t2ofc_pkg::T2OFC_ANSWER;
                    next_pready = 1'b1;
                    // read data is a snapshot of the setup edge, so a count
                    // read may lag the running counter by one tick
                    unique case (decode(PADDR_IN))
                        t2ofc_pkg::T2OFC_REG_CONTROL:
                        begin
                            next_prdata[7:0] = ctl;
                            next_prdata[t2ofc_pkg::UNUSED_BIT] = 1'b0;
                        end
                        t2ofc_pkg::T2OFC_REG_RELOAD: next_prdata[15:0] = reload;
                        t2ofc_pkg::T2OFC_REG_COUNT: next_prdata[15:0] = count;
                        t2ofc_pkg::T2OFC_REG_STATUS: next_prdata[1:0] = irq_status;
                        t2ofc_pkg::T2OFC_REG_MASK: next_prdata[1:0] = irq_mask;
                        t2ofc_pkg::T2OFC_REG_CONFIG: next_prdata[2:0] = cfg;
                        t2ofc_pkg::T2OFC_REG_NONE: next_pslverr = 1'b1;
                        default: next_pslverr = 1'b1;
                    endcase
                end
            end
            t2ofc_pkg::T2OFC_ANSWER:
            begin
                next_phase = t2ofc_pkg::T2OFC_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers written by software
    // ----------------------------------------------------------------
    // flags: a hardware set in the same cycle as a software clear wins
    always_comb
    begin
        next_ctl = ctl;
        next_reload = reload;
        next_cfg = cfg;
        next_irq_mask = irq_mask;
        if (wr_reg == t2ofc_pkg::T2OFC_REG_CONTROL)
        begin
            next_ctl = PWDATA_IN[7:0];
        end
        next_ctl.unused_zero = 1'b0;
        // flags only drop when software writes them; nothing else clears,
        // interrupt entry included
        if (set_hi)
        begin
            next_ctl.high_byte_overflow_flag = 1'b1;
        end
        if (set_lo)
        begin
            next_ctl.low_byte_overflow_flag = 1'b1;
        end
        // a capture outranks a software write to the reload pair, since
        // losing a measured count would spoil the next frequency reading
        if (capture)
        begin
            next_reload = count;
        end
        else if (wr_reg == t2ofc_pkg::T2OFC_REG_RELOAD)
        begin
            next_reload = PWDATA_IN[15:0];
        end
        if (wr_reg == t2ofc_pkg::T2OFC_REG_CONFIG)
        begin
            next_cfg = PWDATA_IN[2:0];
        end
        if (wr_reg == t2ofc_pkg::T2OFC_REG_MASK)
        begin
            next_irq_mask = PWDATA_IN[1:0];
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    // sticky event status, write one to clear, set wins over clear
    always_comb
    begin
        next_irq_status = irq_status;
        if (wr_reg == t2ofc_pkg::T2OFC_REG_STATUS)
        begin
            next_irq_status = irq_status & ~PWDATA_IN[1:0];
        end
        next_irq_status[t2ofc_pkg::STAT_HIGH_BIT] =
            next_irq_status[t2ofc_pkg::STAT_HIGH_BIT] | set_hi;
        next_irq_status[t2ofc_pkg::STAT_LOW_BIT] =
            next_irq_status[t2ofc_pkg::STAT_LOW_BIT] | set_lo;
    end

    // interrupt lines are built from registered state only, so each one
    // lags its source by a cycle but can never glitch
    always_comb
    begin
        next_irq = |(irq_status & irq_mask);
        // timer request follows the high flag, and the low flag when its enable is set, gated by the global enable;
        // a flag set by software raises it just as a hardware event does
        next_timer_irq = cfg[t2ofc_pkg::CFG_TIMER_IRQ_EN_BIT] &&
            (ctl.high_byte_overflow_flag ||
             (ctl.low_byte_overflow_flag && ctl.low_byte_irq_enable));
    end

    // ----------------------------------------------------------------
    // register stage
    // ----------------------------------------------------------------
    // one register stage for every group; all outputs leave from here
    always_ff @(posedge MCLK_IN)
    begin
        if (!RESET_N_IN)
        begin
            ctl <= t2ofc_pkg::TIMER2_CONTROL_RESET;
            reload <= t2ofc_pkg::RELOAD_RESET;
            cfg <= t2ofc_pkg::CONFIG_RESET;
            irq_status <= t2ofc_pkg::IRQ_RESET;
            irq_mask <= t2ofc_pkg::IRQ_RESET;
            phase <= t2ofc_pkg::T2OFC_IDLE;
            div12 <= 4'h0;
            ext_div <= 3'h0;
            ext_prev <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            IRQ_OUT <= 1'b0;
            TIMER_IRQ_OUT <= 1'b0;
        end
        else
        begin
            ctl <= next_ctl;
            reload <= next_reload;
            cfg <= next_cfg;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            phase <= next_phase;
            div12 <= next_div12;
            ext_div <= next_ext_div;
            ext_prev <= ext_level;
            PRDATA_OUT <= next_prdata;
            PREADY_OUT <= next_pready;
            PSLVERR_OUT <= next_pslverr;
            IRQ_OUT <= next_irq;
            TIMER_IRQ_OUT <= next_timer_irq;
        end
    end
endmodule

// ### inc/t2ofc_pkg.sv
// constants and types shared by the timer 2 overflow flag control block
//
// Functional notes
// - high byte rolling FF to 00 sets high flag
// - 16-bit mode: FFFF to 0000 sets high flag
// - enabled timer interrupt requested from set high flag
// - low byte rollover sets low flag, both modes
// - flags never auto-clear; only software writes zero
// - low flag also interrupts when low enable set
// - split off: one 16-bit counter reloading on overflow
package t2ofc_pkg;

    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] TIMER2_CONTROL_ADDR = 8'hC8;
    localparam logic [7:0] RELOAD_ADDR = 8'hCC;
    localparam logic [7:0] COUNT_ADDR = 8'hD0;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'hD4;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'hD8;
    localparam logic [7:0] CONFIG_ADDR = 8'hDC;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int UNUSED_BIT = 1;
    localparam int CFG_TIMER_IRQ_EN_BIT = 0;
    localparam int CFG_HIGH_SYSCLK_BIT = 1;
    localparam int CFG_LOW_SYSCLK_BIT = 2;
    localparam int STAT_HIGH_BIT = 0;
    localparam int STAT_LOW_BIT = 1;
    localparam logic [7:0] TIMER2_CONTROL_RESET = 8'h00;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [2:0] CONFIG_RESET = 3'h0;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // ----------------------------------------------------------------
    // prescaler counts
    // ----------------------------------------------------------------
    localparam logic [3:0] SYSCLK_DIV = 4'hC;
    localparam logic [2:0] EXT_DIV_LAST = 3'h7;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    // control register, laid out bit 7 down to bit 0
    typedef struct packed {
        logic high_byte_overflow_flag;
        logic low_byte_overflow_flag;
        logic low_byte_irq_enable;
        logic capture_mode_enable;
        logic split_mode_select;
        logic timer_run_control;
        logic unused_zero;
        logic external_clock_select;
    } t2ofc_ctrl_type;

    typedef enum logic [2:0] {
        T2OFC_REG_CONTROL = 3'h0,
        T2OFC_REG_RELOAD = 3'h1,
        T2OFC_REG_COUNT = 3'h2,
        T2OFC_REG_STATUS = 3'h3,
        T2OFC_REG_MASK = 3'h4,
        T2OFC_REG_CONFIG = 3'h5,
        T2OFC_REG_NONE = 3'h7
    } t2ofc_reg_type;

    typedef enum logic [0:0] {
        T2OFC_IDLE = 1'b0,
        T2OFC_ANSWER = 1'b1
    } t2ofc_phase_type;

endpackage

// ### core/t2ofc_sync.sv
// three-stage synchroniser with agreement filter for a pin input
module t2ofc_sync
(
    input wire logic MCLK_IN,
    input wire logic RESET_N_IN,
    input wire logic pin_in,
    output logic level_out
);
    logic s1;
    logic s2;
    logic s3;
    logic next_level;

    // a change counts only once stages two and three agree
    always_comb
    begin
        next_level = level_out;
        if (s2 == s3)
        begin
            next_level = s3;
        end
    end

    // s1 is read by s2 alone to keep metastability contained
    always_ff @(posedge MCLK_IN)
    begin
        if (!RESET_N_IN)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level_out <= 1'b0;
        end
        else
        begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            level_out <= next_level;
        end
    end
endmodule

// ### core/t2ofc_count.sv
// timer 2 counting datapath: 16-bit or split 8-bit auto-reload
module t2ofc_count
(
    input wire logic MCLK_IN,
    input wire logic RESET_N_IN,
    input wire t2ofc_pkg::t2ofc_ctrl_type ctl_in,
    input wire logic tick_lo_in,
    input wire logic tick_hi_in,
    input wire logic [15:0] reload_in,
    output logic [15:0] count_out,
    output logic ovf_lo_out,
    output logic ovf_hi_out
);
    logic [15:0] next_count;
    logic next_ovf_lo;
    logic next_ovf_hi;

    // next count and rollover pulses
    always_comb
    begin
        next_count = count_out;
        next_ovf_lo = 1'b0;
        next_ovf_hi = 1'b0;
        if (!ctl_in.split_mode_select)
        begin
            if (ctl_in.timer_run_control && tick_lo_in)
            begin
                if (count_out == 16'hFFFF)
                begin
                    next_count = reload_in;
                    next_ovf_hi = 1'b1;
                    next_ovf_lo = 1'b1;
                end
                else
                begin
                    next_count = count_out + 16'h0001;
                    next_ovf_lo = (count_out[7:0] == 8'hFF);
                end
            end
        end
        else
        begin
            // low byte free-runs in split mode, run bit gates the high byte
            if (tick_lo_in)
            begin
                next_ovf_lo = (count_out[7:0] == 8'hFF);
                next_count[7:0] = next_ovf_lo ? reload_in[7:0] : count_out[7:0] + 8'h01;
            end
            if (ctl_in.timer_run_control && tick_hi_in)
            begin
                next_ovf_hi = (count_out[15:8] == 8'hFF);
                next_count[15:8] = next_ovf_hi ? reload_in[15:8] : count_out[15:8] + 8'h01;
            end
        end
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (!RESET_N_IN)
        begin
            count_out <= t2ofc_pkg::COUNT_RESET;
            ovf_lo_out <= 1'b0;
            ovf_hi_out <= 1'b0;
        end
        else
        begin
            count_out <= next_count;
            ovf_lo_out <= next_ovf_lo;
            ovf_hi_out <= next_ovf_hi;
        end
    end
endmodule

// ### bench/t2ofc_monitor.sv
// checker for the timer 2 control block's bus and interrupt outputs
module t2ofc_monitor
(
    input wire logic MCLK_IN,
    input wire logic RESET_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic EXT_CLK_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic IRQ_OUT,
    input wire logic TIMER_IRQ_OUT
);
    timeunit 1ns;
    timeprecision 100ps;
    logic wr_done;
    logic ctl_wr;
    logic irq_wr;

    // ----------------------------------------
    // completed writes that may lower an interrupt
    // ----------------------------------------
    // only software may drop a request, so a fall must follow such a write
    assign wr_done = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;
    assign ctl_wr = wr_done && (PADDR_IN == 8'hC8 || PADDR_IN == 8'hDC);
    assign irq_wr = wr_done && (PADDR_IN == 8'hD4 || PADDR_IN == 8'hD8);

    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_ready_pulse; PREADY_OUT |=> !PREADY_OUT; endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready held over one cycle");
    property p_ready_answer; PSEL_IN && !PENABLE_IN && !PREADY_OUT |=> PREADY_OUT; endproperty
    a_ready_answer: assert property (p_ready_answer)
        else $error("no ready after setup");
    property p_ready_access; PREADY_OUT |-> PSEL_IN && PENABLE_IN; endproperty
    a_ready_access: assert property (p_ready_access)
        else $error("ready outside access phase");
    property p_err_ready; PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 32'h0; endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("error without ready or with data");
    property p_rdata_idle; !PREADY_OUT |-> PRDATA_OUT == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside answer");
    property p_unused_zero;
        PREADY_OUT && !PWRITE_IN && PADDR_IN == 8'hC8 |-> PRDATA_OUT[1] == 1'b0
            && PRDATA_OUT[31:8] == 24'h0 && !PSLVERR_OUT;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("control unused bit not zero");
    property p_flag_sticky; $fell(TIMER_IRQ_OUT) |-> $past(ctl_wr, 2); endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("timer request fell without a write");
    property p_status_sticky; $fell(IRQ_OUT) |-> $past(irq_wr, 2); endproperty
    a_status_sticky: assert property (p_status_sticky)
        else $error("interrupt fell without a write");
endmodule

bind t2ofc_top t2ofc_monitor u_mon (.MCLK_IN, .RESET_N_IN, .PSEL_IN, .PENABLE_IN,
    .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .EXT_CLK_IN, .PRDATA_OUT, .PREADY_OUT,
    .PSLVERR_OUT, .IRQ_OUT, .TIMER_IRQ_OUT);

// ### bench/test_timer2_overflow_flag_control.sv
// self-checking testbench of the timer 2 overflow flag control block
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module test_timer2_overflow_flag_control;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic ext_clk = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic tirq;
    logic [31:0] rd;
    logic er;
    int n_mismatch = 0;
    int comparisons = 0;

    t2ofc_top uut (.MCLK_IN(mclk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .EXT_CLK_IN(ext_clk),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .IRQ_OUT(irq),
        .TIMER_IRQ_OUT(tirq));

    // 100 MHz system clock
    always #5 mclk = ~mclk;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // one transfer; ready, read data and error are taken at the rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge mclk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        er = pslverr;
        if (i == 20)
        begin
            n_mismatch++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        apb(1'b0, 8'hC8, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 8'hD0, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 8'h10, 32'h0);
        `CHK(er, 1'b1)
        apb(1'b1, 8'hC8, 32'h0000_0003);
        apb(1'b0, 8'hC8, 32'h0);
        `CHK(rd, 32'h0000_0001)
        $display("reset and map test done");
    endtask

    // split mode: low byte free running, high byte gated by run
    task automatic t_split;
        apb(1'b1, 8'hDC, 32'h7);
        apb(1'b1, 8'hCC, 32'hF0F0);
        apb(1'b1, 8'hC8, 32'h08);
        wt(300);
        apb(1'b0, 8'hC8, 32'h0);
        `CHK(rd, 32'h48)
        `CHK(tirq, 1'b0)
        apb(1'b1, 8'hC8, 32'h68);
        wt(2);
        `CHK(tirq, 1'b1)
        apb(1'b1, 8'hC8, 32'h0C);
        wt(300);
        apb(1'b0, 8'hC8, 32'h0);
        `CHK(rd, 32'hCC)
        $display("split mode test done");
    endtask

    // 16-bit mode from a count near the top; flags must outlive the stop
    task automatic t_wide;
        int i;
        // stop first, so no split-mode rollover can land on the clearing write
        apb(1'b1, 8'hC8, 32'h00);
        apb(1'b1, 8'hC8, 32'h04);
        wt(2);
        `CHK(tirq, 1'b0)
        for (i = 0; i < 5000 && tirq !== 1'b1; i++)
            wt(1);
        if (i == 5000)
        begin
            n_mismatch++;
            end_of_test();
        end
        `CHK(tirq, 1'b1)
        apb(1'b0, 8'hC8, 32'h0);
        `CHK(rd, 32'hC4)
        apb(1'b1, 8'hC8, 32'hC0);
        wt(30);
        apb(1'b0, 8'hC8, 32'h0);
        `CHK(rd, 32'hC0)
        `CHK(tirq, 1'b1)
        apb(1'b0, 8'hD0, 32'h0);
        `CHK(rd[15:8], 8'hF0)
        apb(1'b1, 8'hC8, 32'h00);
        wt(2);
        `CHK(tirq, 1'b0)
        $display("wide mode test done");
    endtask

    // status bits are sticky, masked, and cleared by writing ones
    task automatic t_irq;
        apb(1'b0, 8'hD4, 32'h0);
        `CHK(rd, 32'h3)
        `CHK(irq, 1'b0)
        apb(1'b1, 8'hD8, 32'h1);
        wt(2);
        `CHK(irq, 1'b1)
        apb(1'b1, 8'hD4, 32'h1);
        wt(2);
        `CHK(irq, 1'b0)
        apb(1'b0, 8'hD4, 32'h0);
        `CHK(rd, 32'h2)
        $display("interrupt test done");
    endtask

    // capture on every eighth external edge: count to reload, high flag set
    task automatic t_capture;
        int k;
        apb(1'b1, 8'hC8, 32'h14);
        for (k = 0; k < 8; k++)
        begin
            if (k == 7)
            begin
                apb(1'b0, 8'hC8, 32'h0);
                `CHK(rd[7], 1'b0)
            end
            @(posedge mclk);
            ext_clk <= 1'b1;
            repeat (4) @(posedge mclk);
            ext_clk <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        wt(10);
        `CHK(tirq, 1'b1)
        `CHK(irq, 1'b1)
        apb(1'b0, 8'hCC, 32'h0);
        `CHK(rd[15:0] == 16'hF0F0, 1'b0)
        apb(1'b0, 8'hC8, 32'h0);
        `CHK(rd[7], 1'b1)
        apb(1'b1, 8'hC8, 32'h00);
        $display("capture test done");
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_split();
        t_wide();
        t_irq();
        t_capture();
        end_of_test();
    end
endmodule
